// ===== hw/spu_pkg.sv
/*
  Shared constants, types and helpers for the serial peripheral unit.
  Assumes a single system clock domain plus a free-running link clock
  on which the external master drives its pins.
*/
// Summary of operation
// RULE1 - The unit runs as bus master or as bus slave on a four-wire bus.
// RULE2 - As master the serial bit rate never exceeds half the system clock.
// RULE3 - As full-duplex slave, bit rates up to a tenth of system clock work.
// RULE4 - An asynchronous external master keeps its rate below a tenth of system clock.
// RULE5 - As receive-only slave, bit rates up to a quarter of system clock work.
// RULE6 - The master-out line is driven as master and is an input as slave.
// RULE7 - Every word travels most significant bit first on both data lines.
// RULE8 - The master-in line is an input as master and driven as slave.
// RULE9 - A slave that is not selected releases its master-in output.
// RULE10 - The serial clock is driven only in master mode.
// RULE11 - Slave select is always an input; slave selects come from other pins.
// RULE12 - A low slave select disables master operation.
// RULE13 - Two masters transferring at once are detected as a collision.
// RULE14 - Slave transfers start on select low and end on select high.
// RULE15 - Slave receive data reaches the buffer only after select goes high.
// RULE16 - The master holds select high at least four system clocks between bytes.
// RULE17 - A data write in master mode starts a transfer at once.
// RULE18 - A mode fault clears both the master and unit enables.
// RULE19 - The frame size field selects one to eight bits per master transfer.
// RULE20 - Phase picks first or second edge for sampling, polarity the idle level.
// RULE21 - Slave inputs pass two flip-flops into the system clock domain.
package spu_pkg;

  localparam int DATA_W = 8;
  localparam int FRAME_W = 3;
  localparam int CLK_DIV_W = 8;
  localparam int EDGE_W = 5;

  // A half period of two system clocks covers the master-in synchroniser delay.
  localparam int MIN_HALF_CYC = 2;

  localparam logic SS_IDLE = 1'b1;

  typedef enum logic [0:0] {XF_IDLE, XF_RUN} xfer_t;

  // True when edge index n (edges counted from 1) is a sampling edge.
  function automatic logic sample_slot(input logic phase, input logic [EDGE_W-1:0] n);
    sample_slot = phase ? (~n[0] && (n != '0)) : n[0];
  endfunction

endpackage

// ===== hw/link_pins_if.sv
/*
  Captured slave-side pin levels passed from the link-clock front end to
  the system-clock core. Assumes the core re-synchronises every signal.
*/
`timescale 1ns/1ps
interface link_pins_if;
  logic sck;
  logic mosi;
  logic ss_n;
  modport drive (output sck, output mosi, output ss_n);
  modport take (input sck, input mosi, input ss_n);
endinterface

// ===== hw/link_pin_capture.sv
/*
  Link-clock front end: registers the serial clock, master-out and slave
  select pins on the clock to which the external master is synchronous.
  Assumes that clock runs freely; the core crosses the levels itself.
*/
`timescale 1ns/1ps
module link_pin_capture (
  // Clock and reset
  input wire logic i_clk_link,
  input wire logic i_rst_b,
  // Pins from the bus
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_ss_n,
  // Captured levels
  link_pins_if.drive lp
);

  typedef struct packed {
    logic sck;
    logic mosi;
    logic ss_n;
  } cap_t;

  cap_t s;
  cap_t n;

  always_comb begin
    n = s;
    n.sck = i_sck;
    n.mosi = i_mosi;
    n.ss_n = i_ss_n;
  end

  always_ff @(posedge i_clk_link or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '{sck: 1'b0, mosi: 1'b0, ss_n: spu_pkg::SS_IDLE};
    end else begin
      s <= n;
    end
  end

  assign lp.sck = s.sck;
  assign lp.mosi = s.mosi;
  assign lp.ss_n = s.ss_n;

endmodule

// ===== hw/serial_periph_unit.sv
/*
  Serial peripheral unit: master or slave on a four-wire full-duplex bus.
  Control and status bits are plain ports on the system clock. Assumes the
  external master drives its pins synchronously with I_CLK_LINK.
*/
`timescale 1ns/1ps
module serial_periph_unit #(
  parameter int DIV_W = spu_pkg::CLK_DIV_W
) (
  // Clocks and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_CLK_LINK,
  // Control writes
  input wire logic I_CTRL_WR,
  input wire logic I_UNIT_ENABLE,
  input wire logic I_MASTER_ENABLE,
  // Configuration
  input wire logic I_CLOCK_PHASE,
  input wire logic I_CLOCK_POLARITY,
  input wire logic [spu_pkg::FRAME_W-1:0] I_FRAME_SIZE,
  input wire logic [DIV_W-1:0] I_CLK_DIV,
  // Data access
  input wire logic I_DATA_WR,
  input wire logic [spu_pkg::DATA_W-1:0] I_DATA_WDATA,
  input wire logic I_DATA_RD,
  // Flag clears
  input wire logic I_CLR_DONE,
  input wire logic I_CLR_WCOL,
  input wire logic I_CLR_MODE_FAULT_FLAG,
  input wire logic I_CLR_OVRN,
  // Bus pins
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE_B,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE_B,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE_B,
  input wire logic I_SLAVE_SELECT_IN_N,
  // Status
  output logic [spu_pkg::DATA_W-1:0] O_RX_DATA,
  output logic O_RX_FULL,
  output logic O_DONE_FLAG,
  output logic O_WCOL_FLAG,
  output logic O_MODE_FAULT_FLAG,
  output logic O_OVRN_FLAG,
  output logic O_BUSY,
  output logic O_SLAVE_SELECTED,
  output logic O_MASTER_ENABLE,
  output logic O_UNIT_ENABLE,
  output logic [spu_pkg::FRAME_W-1:0] O_BIT_COUNT
);

  localparam int DW = spu_pkg::DATA_W;
  localparam int EW = spu_pkg::EDGE_W;
  localparam logic [DIV_W-1:0] HALF_MIN = DIV_W'(spu_pkg::MIN_HALF_CYC - 1);

  typedef struct packed {
    spu_pkg::xfer_t xf;
    logic unit_en;
    logic master_en;
    logic done;
    logic wcol;
    logic mode_fault_flag;
    logic ovrn;
    logic [DW-1:0] sh;
    logic [DW-1:0] rx_sh;
    logic [DW-1:0] rx_buf;
    logic rx_full;
    logic [DIV_W-1:0] half_cnt;
    logic [EW-1:0] edge_n;
    logic [EW-1:0] edge_end;
    logic sck_o;
    logic miso_1;
    logic miso_2;
    logic sck_1;
    logic sck_2;
    logic sck_3;
    logic ss_1;
    logic ss_2;
    logic mosi_1;
    logic mosi_2;
    logic sel_r;
    logic first_r;
  } st_t;

  // Select stages start at the idle level, so no false mode fault follows reset.
  localparam st_t ST_RST = '{
    xf: spu_pkg::XF_IDLE,
    ss_1: spu_pkg::SS_IDLE,
    ss_2: spu_pkg::SS_IDLE,
    default: '0
  };

  st_t s;
  st_t n;

  link_pins_if lp ();

  link_pin_capture u_capture (
    .i_clk_link (I_CLK_LINK),
    .i_rst_b (I_RST_B),
    .i_sck (I_SCK),
    .i_mosi (I_MOSI),
    .i_ss_n (I_SLAVE_SELECT_IN_N),
    .lp (lp.drive)
  );

  logic sel_now;
  logic fault;
  logic busy;
  logic sck_edge;
  logic leading;
  logic samp_ev;
  logic shift_ev;
  logic [DIV_W-1:0] half_lim;

  // Selected as slave only when enabled and not configured as master.
  assign sel_now = s.unit_en & ~s.master_en & ~s.ss_2; // RULE1 RULE14
  // Select low while master: collision with another master.
  assign fault = s.master_en & ~s.ss_2; // RULE11 RULE12 RULE13
  assign busy = (s.xf == spu_pkg::XF_RUN) | s.sel_r;
  // Every half period is at least two system clocks.
  assign half_lim = (I_CLK_DIV < HALF_MIN) ? HALF_MIN : I_CLK_DIV; // RULE2
  assign sck_edge = s.sck_2 ^ s.sck_3;
  assign leading = (s.sck_3 == I_CLOCK_POLARITY);
  assign samp_ev = sck_edge & (leading ^ I_CLOCK_PHASE); // RULE20
  assign shift_ev = sck_edge & ~(leading ^ I_CLOCK_PHASE); // RULE20

  always_comb begin
    n = s;
    // Two stages before use; slave rate is bounded by this latency.
    n.miso_1 = I_MISO;
    n.miso_2 = s.miso_1;
    n.sck_1 = lp.sck; // RULE21 RULE3 RULE5
    n.sck_2 = s.sck_1;
    n.sck_3 = s.sck_2;
    n.ss_1 = lp.ss_n; // RULE21
    n.ss_2 = s.ss_1;
    n.mosi_1 = lp.mosi; // RULE21
    n.mosi_2 = s.mosi_1;
    // Clears come first so that a set in the same cycle wins.
    if (I_CLR_DONE) begin
      n.done = 1'b0;
    end
    if (I_CLR_WCOL) begin
      n.wcol = 1'b0;
    end
    if (I_CLR_MODE_FAULT_FLAG) begin
      n.mode_fault_flag = 1'b0;
    end
    if (I_CLR_OVRN) begin
      n.ovrn = 1'b0;
    end
    if (I_DATA_RD) begin
      n.rx_full = 1'b0;
    end
    if (I_CTRL_WR) begin
      n.unit_en = I_UNIT_ENABLE;
      n.master_en = I_MASTER_ENABLE;
    end
    if (I_DATA_WR) begin
      if (busy) begin
        n.wcol = 1'b1;
      end else begin
        n.sh = I_DATA_WDATA;
        if (s.unit_en & s.master_en & s.ss_2) begin
          n.xf = spu_pkg::XF_RUN; // RULE17
          n.half_cnt = '0;
          n.edge_n = '0;
          n.edge_end = EW'((32'(I_FRAME_SIZE) + 1) * 2); // RULE19
        end
      end
    end
    unique case (s.xf)
      spu_pkg::XF_IDLE: begin
        n.sck_o = I_CLOCK_POLARITY; // RULE20
      end
      spu_pkg::XF_RUN: begin
        if (s.half_cnt != half_lim) begin
          n.half_cnt = DIV_W'(s.half_cnt + 1'b1);
        end else begin
          n.half_cnt = '0;
          // Capture one half period after the sampling edge, then shift.
          if (spu_pkg::sample_slot(I_CLOCK_PHASE, s.edge_n)) begin
            n.sh = {s.sh[DW-2:0], s.miso_2}; // RULE7 RULE8
          end
          if (s.edge_n == s.edge_end) begin
            n.xf = spu_pkg::XF_IDLE;
            n.done = 1'b1;
            n.rx_buf = n.sh;
            n.rx_full = 1'b1;
          end else begin
            n.edge_n = EW'(s.edge_n + 1'b1);
            n.sck_o = ~s.sck_o; // RULE10
          end
        end
      end
    endcase
    n.sel_r = sel_now;
    if (sel_now & ~s.sel_r) begin
      n.first_r = 1'b1;
    end
    if (sel_now & s.sel_r) begin
      if (samp_ev) begin
        n.rx_sh = {s.rx_sh[DW-2:0], s.mosi_2}; // RULE7
      end
      // With phase 1 the first leading edge presents the MSB already loaded.
      if (shift_ev & ~s.first_r) begin
        n.sh = {s.sh[DW-2:0], 1'b0}; // RULE7
      end
      if (sck_edge) begin
        n.first_r = 1'b0;
      end
    end
    // End of a slave frame: only now does the buffer take the word.
    if (s.sel_r & ~sel_now) begin
      n.done = 1'b1; // RULE14
      if (n.rx_full) begin
        n.ovrn = 1'b1;
      end else begin
        n.rx_buf = s.rx_sh; // RULE15
        n.rx_full = 1'b1;
      end
    end
    if (fault) begin
      n.mode_fault_flag = 1'b1; // RULE18 RULE13
      n.unit_en = 1'b0;
      n.master_en = 1'b0;
      n.xf = spu_pkg::XF_IDLE; // RULE12
      n.sck_o = I_CLOCK_POLARITY; // RULE10
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign O_SCK = s.sck_o;
  assign O_SCK_OE_B = ~(s.unit_en & s.master_en); // RULE10
  assign O_MOSI = s.sh[DW-1];
  assign O_MOSI_OE_B = ~(s.unit_en & s.master_en); // RULE6
  assign O_MISO = s.sh[DW-1];
  assign O_MISO_OE_B = ~s.sel_r; // RULE8 RULE9
  assign O_RX_DATA = s.rx_buf;
  assign O_RX_FULL = s.rx_full;
  assign O_DONE_FLAG = s.done;
  assign O_WCOL_FLAG = s.wcol;
  assign O_MODE_FAULT_FLAG = s.mode_fault_flag;
  assign O_OVRN_FLAG = s.ovrn;
  assign O_BUSY = busy;
  assign O_SLAVE_SELECTED = s.sel_r;
  assign O_MASTER_ENABLE = s.master_en;
  assign O_UNIT_ENABLE = s.unit_en;
  assign O_BIT_COUNT = s.edge_n[spu_pkg::FRAME_W:1];

  // Helper for the checks: counts serial clock toggles in a master frame.
  logic [EW-1:0] tog_cnt;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tog_cnt <= '0;
    end else if (s.xf == spu_pkg::XF_IDLE) begin
      tog_cnt <= '0;
    end else if (n.sck_o != s.sck_o) begin
      tog_cnt <= EW'(tog_cnt + 1'b1);
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  mode_fault_clear_a: assert property ( // RULE18
    s.master_en && !s.ss_2 |=> O_MODE_FAULT_FLAG && !O_MASTER_ENABLE && !O_UNIT_ENABLE)
    else $error("mode fault did not take the unit off-line");

  miso_release_a: assert property ( // RULE9
    s.ss_2 |=> O_MISO_OE_B)
    else $error("master-in driven while not selected");

  pin_direction_a: assert property ( // RULE6
    !(!O_MOSI_OE_B && !O_MISO_OE_B))
    else $error("both data lines driven at once");

  sck_rate_a: assert property ( // RULE2
    s.xf == spu_pkg::XF_RUN && $changed(O_SCK) |=> !$changed(O_SCK))
    else $error("serial clock faster than half the system clock");

  sck_master_only_a: assert property ( // RULE10
    !O_MASTER_ENABLE && $stable(I_CLOCK_POLARITY) [*2] |-> O_SCK == I_CLOCK_POLARITY)
    else $error("serial clock toggling outside master mode");

  write_start_a: assert property ( // RULE17
    I_DATA_WR && !busy && s.unit_en && s.master_en && s.ss_2 && !fault
    |=> s.xf == spu_pkg::XF_RUN)
    else $error("data write in master mode did not start a transfer");

  write_collide_a: assert property (
    I_DATA_WR && busy |=> O_WCOL_FLAG && $stable(s.edge_end))
    else $error("write during a transfer not flagged");

  frame_length_a: assert property ( // RULE19
    s.xf == spu_pkg::XF_RUN && n.xf == spu_pkg::XF_IDLE && !fault
    |-> tog_cnt == EW'((32'(s.edge_end[EW-1:1])) * 2) && s.edge_n == s.edge_end)
    else $error("master frame had the wrong number of clock edges");

  rx_latch_a: assert property ( // RULE15
    s.sel_r && sel_now |=> $stable(O_RX_DATA))
    else $error("slave buffer changed before select went high");

  rx_take_a: assert property ( // RULE14
    s.sel_r && !sel_now && !s.rx_full && !I_DATA_RD |=> O_RX_DATA == $past(s.rx_sh) && O_DONE_FLAG)
    else $error("slave word not taken at end of frame");

  master_done_c: cover property (
    s.xf == spu_pkg::XF_RUN ##1 s.xf == spu_pkg::XF_IDLE && O_DONE_FLAG);
  slave_frame_c: cover property (s.sel_r ##1 !s.sel_r && O_RX_FULL);
  mode_fault_c: cover property ($rose(O_MODE_FAULT_FLAG));
  overrun_c: cover property ($rose(O_OVRN_FLAG));

endmodule

// ===== tb/spi_far_end.sv
/*
  Far end of the bus: a slave for the unit as master, and a master on
  the link clock for the unit as slave. Assumes the bench resolves pins.
*/
`timescale 1ns/1ps
module spi_far_end (
  // Clock and mode
  input wire logic i_clk_link,
  input wire logic i_pha,
  input wire logic i_pol,
  // Slave side
  input wire logic i_sel_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  // Master side
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_ss_n
);
  logic [7:0] tx = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic first = 1'b1;
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_ss_n = 1'b1;
  end
  // A released line shows the inverse of its last bit.
  assign o_miso = i_sel_n ? ~sh[7] : sh[7];
  always @(negedge i_sel_n) begin
    sh = tx;
    first = 1'b1;
  end
  always @(i_sck) begin
    if (!i_sel_n && (i_sck ^ i_pol ^ i_pha)) begin
      rx = {rx[6:0], i_mosi};
    end else if (!i_sel_n && i_pha && first) begin
      first = 1'b0;
    end else if (!i_sel_n) begin
      sh = {sh[6:0], 1'b0};
    end
  end
  task automatic xfer(input logic [7:0] d, output logic [7:0] got);
    @(posedge i_clk_link);
    o_sck <= i_pol;
    @(posedge i_clk_link);
    o_ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!i_pha) o_mosi <= d[i];
      repeat (6) @(posedge i_clk_link);
      if (!i_pha) got[i] = i_miso;
      if (i_pha) o_mosi <= d[i];
      o_sck <= ~i_pol;
      repeat (6) @(posedge i_clk_link);
      if (i_pha) got[i] = i_miso;
      o_sck <= i_pol;
    end
    repeat (6) @(posedge i_clk_link);
  endtask
  task automatic drop();
    @(posedge i_clk_link);
    o_ss_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (4) @(posedge i_clk_link);
  endtask
endmodule

// ===== tb/testbench.sv
/*
  Self-checking bench for the serial peripheral unit as master and slave.
  Assumes the far-end model and a free-running link clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic clk = 1'b0, lclk = 1'b0, rst_b = 1'b0, cwr = 1'b0, ue = 1'b0, me = 1'b0;
  logic pha = 1'b0, pol = 1'b0, dwr = 1'b0, drd = 1'b0, cd = 1'b0, cw = 1'b0;
  logic cm = 1'b0, co = 1'b0, sel_n = 1'b1, flt_n = 1'b1;
  logic [2:0] fsz = 3'h7;
  logic [7:0] wd = 8'h00, rxd;
  logic [7:0] div = 8'h03;
  logic [2:0] bc;
  logic sck_o, sck_oe_b, mosi_o, mosi_oe_b, miso_o, miso_oe_b, f_sck, f_mosi;
  logic f_miso, f_ss_n, full, done, wcol, mode_fault_flag, ovrn, busy, ssel, men, uen;
  int fails = 0, tests_run = 0, cyc = 0, i, k;
  wire sck_w = !sck_oe_b ? sck_o : f_sck;
  wire mosi_w = !mosi_oe_b ? mosi_o : f_mosi;
  wire miso_w = !miso_oe_b ? miso_o : f_miso;
  wire ss_w = f_ss_n & flt_n;
  serial_periph_unit DUT (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_CLK_LINK(lclk),
    .I_CTRL_WR(cwr), .I_UNIT_ENABLE(ue), .I_MASTER_ENABLE(me),
    .I_CLOCK_PHASE(pha), .I_CLOCK_POLARITY(pol), .I_FRAME_SIZE(fsz), .I_CLK_DIV(div),
    .I_DATA_WR(dwr), .I_DATA_WDATA(wd), .I_DATA_RD(drd),
    .I_CLR_DONE(cd), .I_CLR_WCOL(cw), .I_CLR_MODE_FAULT_FLAG(cm), .I_CLR_OVRN(co),
    .I_SCK(sck_w), .O_SCK(sck_o), .O_SCK_OE_B(sck_oe_b),
    .I_MOSI(mosi_w), .O_MOSI(mosi_o), .O_MOSI_OE_B(mosi_oe_b),
    .I_MISO(miso_w), .O_MISO(miso_o), .O_MISO_OE_B(miso_oe_b), .I_SLAVE_SELECT_IN_N(ss_w),
    .O_RX_DATA(rxd), .O_RX_FULL(full), .O_DONE_FLAG(done), .O_WCOL_FLAG(wcol),
    .O_MODE_FAULT_FLAG(mode_fault_flag), .O_OVRN_FLAG(ovrn), .O_BUSY(busy), .O_SLAVE_SELECTED(ssel),
    .O_MASTER_ENABLE(men), .O_UNIT_ENABLE(uen), .O_BIT_COUNT(bc)
  );
  spi_far_end far (
    .i_clk_link(lclk), .i_pha(pha), .i_pol(pol), .i_sel_n(sel_n), .i_sck(sck_w),
    .i_mosi(mosi_w), .o_miso(f_miso), .i_miso(miso_w), .o_sck(f_sck), .o_mosi(f_mosi),
    .o_ss_n(f_ss_n)
  );
  always #20 clk = ~clk;
  always #24 lclk = ~lclk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tk();
    @(posedge clk);
    #1;
  endtask
  task automatic ctrl(input logic u, input logic m);
    tk();
    {cwr, ue, me} = {1'b1, u, m};
    tk();
    cwr = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    tk();
    {dwr, wd} = {1'b1, d};
    tk();
    dwr = 1'b0;
  endtask
  task automatic clr();
    tk();
    {cd, cw, cm, co, drd} = 5'h1f;
    tk();
    {cd, cw, cm, co, drd} = 5'h00;
  endtask
  task automatic wt(input logic ov);
    for (k = 0; k < 800 && (ov ? ovrn : done) !== 1'b1; k++) tk();
    `CHK((ov ? ovrn : done), 1'b1)
  endtask
  // Master transfer of j+1 bits, with a colliding write while busy.
  task automatic mxfer(input int j);
    logic [7:0] d, s, m;
    int n, h;
    d = 8'ha5 ^ j[7:0];
    s = 8'h3c + j[7:0];
    n = j + 1;
    m = 8'hff >> (8 - n);
    ctrl(1'b0, 1'b0);
    {pha, pol, fsz, far.tx} = {j[0], j[1], j[2:0], s};
    // A divider of zero must still give the minimum half period of two clocks.
    div = j[2] ? 8'h00 : 8'h03;
    h = j[2] ? 2 : 4;
    ctrl(1'b1, 1'b1);
    `CHK({sck_o, sck_oe_b, mosi_oe_b, miso_oe_b}, {j[1], 3'b001})
    sel_n = 1'b0;
    wr(d);
    wr(~d);
    tk();
    `CHK({wcol, busy}, 2'b11)
    wt(1'b0);
    sel_n = 1'b1;
    `CHK(k, h * (2 * n + 1) - 3)
    `CHK(bc, 3'(n))
    `CHK(far.rx & m, d >> (8 - n))
    `CHK(rxd, 8'((d << n) | (s >> (8 - n))))
    clr();
    `CHK({done, wcol, full}, 3'b000)
  endtask
  task automatic fault();
    ctrl(1'b1, 1'b1);
    flt_n = 1'b0;
    repeat (8) tk();
    `CHK({mode_fault_flag, men, uen}, 3'b100)
    `CHK({sck_oe_b, mosi_oe_b}, 2'b11)
    flt_n = 1'b1;
    clr();
    `CHK(mode_fault_flag, 1'b0)
  endtask
  // Two slave bytes; the first is left unread so the second forces an overrun.
  task automatic sxfer(input int j);
    logic [7:0] d, t, got;
    d = 8'h5a ^ j[7:0];
    t = 8'hc3 - j[7:0];
    ctrl(1'b0, 1'b0);
    {pha, pol} = j[1:0];
    ctrl(1'b1, 1'b0);
    wr(t);
    far.xfer(d, got);
    `CHK(full, 1'b0)
    `CHK({ssel, miso_oe_b, mosi_oe_b, sck_oe_b}, 4'b1011)
    far.drop();
    wt(1'b0);
    `CHK({rxd, full, miso_oe_b}, {d, 2'b11})
    `CHK(got, t)
    far.xfer(~d, got);
    far.drop();
    wt(1'b1);
    `CHK({ovrn, rxd}, {1'b1, d})
    clr();
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (4) tk();
    `CHK({sck_oe_b, mosi_oe_b, miso_oe_b, uen, men, done}, 6'b111000)
    for (i = 0; i < 8; i++) mxfer(i);
    fault();
    for (i = 0; i < 4; i++) sxfer(i);
    end_sim();
  end
endmodule
